// >>> sim/isa_cycle_ctl_assertions.sv
// Assertions on the ISA cycle control ports
`timescale 1ns/1ps
module isa_cycle_ctl_chk
  import isa_ctl_pkg::*;
(
  // Clock and reset
  input wire logic             REF_CLK,
  input wire logic             SRST,
  // Watched ports
  input wire logic             REQ_READY,
  input wire logic             SBHE_N_O,
  input wire logic             BALE,
  input wire logic             IOR_N,
  input wire logic             IOW_N,
  input wire logic             MEMR_N,
  input wire logic             MEMW_N,
  input wire logic             SMEMR_N,
  input wire logic             CMD_OE_N,
  input wire logic             IOCHRDY,
  input wire logic             IOCHCK_N,
  input wire logic             MASTER_N,
  input wire logic             REFRESH_N_O,
  input wire logic             AEN,
  input wire logic             TC,
  input wire logic [DRQ_W-1:0] DACK_N_O,
  input wire logic             DACK_OE_N,
  input wire logic             CHCK_EVENT,
  input wire logic             NMI,
  input wire logic             RSTDRV
);
  // ************
  // Properties
  // ************
  wire logic cmd_n = &{IOR_N, IOW_N, MEMR_N, MEMW_N};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sbhe_refresh_a: assert property (!REFRESH_N_O |-> SBHE_N_O)
    else $error("byte high enable active in refresh");
  smem_low_a: assert property (!SMEMR_N |-> !MEMR_N)
    else $error("standard read without memory read");
  bale_first_a: assert property ($fell(cmd_n) && !CMD_OE_N |-> $past(BALE))
    else $error("command without address latch");
  one_strobe_a: assert property (!AEN && !CMD_OE_N |-> $onehot0(~{IOR_N, IOW_N, MEMR_N, MEMW_N}))
    else $error("two strobes outside DMA");
  aen_dma_a: assert property ((!DACK_OE_N && !(&DACK_N_O)) || TC |-> AEN)
    else $error("DMA signal without AEN");
  wait_hold_a: assert property ((!cmd_n && !CMD_OE_N && !IOCHRDY) [*3] |=> !cmd_n)
    else $error("command ended while not ready");
  chck_event_a: assert property ($fell(IOCHCK_N) |-> ##[1:5] CHCK_EVENT)
    else $error("channel check not captured");
  nmi_level_a: assert property (!IOCHCK_N [*5] |-> NMI)
    else $error("no NMI on channel check");
  master_hold_a: assert property (!MASTER_N [*4] |-> !REQ_READY)
    else $error("request taken in master cycle");
  rst_drv_a: assert property ($fell(SRST) |-> RSTDRV [*8])
    else $error("bus reset dropped early");
endmodule : isa_cycle_ctl_chk

bind isa_cycle_ctl isa_cycle_ctl_chk i_isa_cycle_ctl_chk (.REF_CLK(REF_CLK), .SRST(SRST),
  .REQ_READY(REQ_READY), .SBHE_N_O(SBHE_N_O), .BALE(BALE), .IOR_N(IOR_N), .IOW_N(IOW_N),
  .MEMR_N(MEMR_N), .MEMW_N(MEMW_N), .SMEMR_N(SMEMR_N), .CMD_OE_N(CMD_OE_N),
  .IOCHRDY(IOCHRDY), .IOCHCK_N(IOCHCK_N), .MASTER_N(MASTER_N), .REFRESH_N_O(REFRESH_N_O),
  .AEN(AEN), .TC(TC), .DACK_N_O(DACK_N_O), .DACK_OE_N(DACK_OE_N),
  .CHCK_EVENT(CHCK_EVENT), .NMI(NMI), .RSTDRV(RSTDRV));

// >>> sim/isa_cycle_ctl_tb.sv
// Self-checking bench of the ISA cycle control block
`timescale 1ns/1ps
module isa_cycle_ctl_tb;
  import isa_ctl_pkg::*;
  // ************
  // Signals
  // ************
  logic        ref_clk = 1'h0, link_clk = 1'h0, srst = 1'h1, req_valid = 1'h0;
  cyc_kind_t   req_kind = CYC_IOR;
  logic [23:0] req_addr = 24'h0;
  logic        req_hi = 1'h0, wide = 1'h0, master_n = 1'h1, ext_refr = 1'h1;
  logic        iochck_n = 1'h1, timer2 = 1'h0, strap = 1'h1;
  logic [7:0]  waits = 8'h0, drq = 8'h0, drq_pend, dack_o, dack_strap;
  logic [6:0]  ext_la = 7'h0, la_o, master_la;
  logic [15:0] irq = 16'h0, irq_sync;
  logic [19:0] sa;
  logic        req_ready, done, done16, la_oe_n, sbhe_n, sbhe_oe_n, bale, ior_n, iow_n;
  logic        memr_n, memw_n, smemr_n, smemw_n, cmd_oe_n, iocs16_n, memcs16_n, iochrdy;
  logic        refr_o, refr_oe_n, master_ref, aen, tc, dack_oe_n, spkr_o, spkr_oe_n;
  logic        reloc, chck_ev, nmi, rstdrv, bclk;
  int          error_cnt = 0, checked = 0;
  // Shared pins resolve from the DUT's output enable alone
  wire logic [6:0] la_i   = la_oe_n ? ext_la : la_o;
  wire logic       refr_i = refr_oe_n ? ext_refr : refr_o;
  wire logic       spkr_i = spkr_oe_n ? strap : spkr_o;
  wire logic [7:0] dack_i = dack_oe_n ? 8'hA5 : dack_o;
  isa_cycle_ctl i_isa_cycle_ctl (.REF_CLK(ref_clk), .SRST(srst), .LINK_CLK(link_clk),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_ADDR(req_addr),
    .REQ_HIGH_BYTE(req_hi), .REQ_TC(req_hi), .REQ_DMA_CH(req_addr[2:0]),
    .REQ_IDE_SEL(req_addr[4:3]), .DONE(done), .DONE_16BIT(done16), .SA_O(sa), .LA_O(la_o),
    .LA_OE_N(la_oe_n), .LA_I(la_i), .MASTER_LA(master_la), .SBHE_N_O(sbhe_n),
    .SBHE_OE_N(sbhe_oe_n), .BALE(bale), .IOR_N(ior_n), .IOW_N(iow_n), .MEMR_N(memr_n),
    .MEMW_N(memw_n), .SMEMR_N(smemr_n), .SMEMW_N(smemw_n), .CMD_OE_N(cmd_oe_n),
    .IOCS16_N(iocs16_n), .MEMCS16_N(memcs16_n), .IOCHRDY(iochrdy), .IOCHCK_N(iochck_n),
    .MASTER_N(master_n), .REFRESH_N_I(refr_i), .REFRESH_N_O(refr_o),
    .REFRESH_N_OE_N(refr_oe_n), .MASTER_REFRESH(master_ref), .AEN(aen), .TC(tc), .DRQ(drq),
    .DRQ_PENDING(drq_pend), .DACK_N_I(dack_i), .DACK_N_O(dack_o), .DACK_OE_N(dack_oe_n),
    .DACK_STRAP(dack_strap), .TIMER2_OUT(timer2), .SPKR_I(spkr_i), .SPKR_O(spkr_o),
    .SPKR_OE_N(spkr_oe_n), .IDE_BASE_RELOC(reloc), .IRQ(irq), .IRQ_SYNC(irq_sync),
    .CHCK_EVENT(chck_ev), .NMI(nmi), .RSTDRV(rstdrv), .BCLK(bclk));
  isa_slave_model i_isa_slave_model (.clk(ref_clk), .cmd_n(ior_n & iow_n & memr_n & memw_n),
    .wide(wide), .waits(waits), .iocs16_n(iocs16_n), .memcs16_n(memcs16_n), .iochrdy(iochrdy));
  initial forever #12.5 ref_clk = ~ref_clk;
  initial
  begin
    #3.1;
    forever #6 link_clk = ~link_clk;
  end
  // ************
  // Tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic cyc(input cyc_kind_t k, input logic [23:0] a, input logic hi, w,
    input logic [7:0] wt);
    logic [3:0]  stb [8];
    logic [13:0] seen, ev;
    logic [7:0]  dk;
    logic        dma, low;
    int          n, len, mn;
    stb = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h2, 4'h6, 4'h9, 4'h0};
    dma = (k == CYC_DMAR) || (k == CYC_DMAW);
    low = a < LOW_MEG_LIMIT;
    ev = {stb[k], stb[k][1] && low, stb[k][0] && low, dma, k == CYC_REFRESH,
      hi && k != CYC_REFRESH && k != CYC_IDE, dma && hi, k != CYC_IDE,
      k != CYC_IDE, k == CYC_REFRESH, 1'h1};
    seen = '0;
    dk = '0;
    len = 0;
    wide = w;
    waits = wt;
    req_kind = k;
    req_addr = a;
    req_hi = hi;
    step(4);
    req_valid = 1'h1;
    for (n = 0; n < 60 && !req_ready; n++) step(1);
    if (req_ready !== 1'h1)
    begin
      error_cnt++;
      summarize();
    end
    step(1);
    req_valid = 1'h0;
    for (n = 0; n < 600 && !done; n++)
    begin
      seen |= {~ior_n, ~iow_n, ~memr_n, ~memw_n, ~smemr_n, ~smemw_n, aen, ~refr_o, ~sbhe_n,
        tc, bale, ~cmd_oe_n, ~refr_oe_n, ~sbhe_oe_n};
      dk |= ~dack_o;
      len += int'(!(ior_n & iow_n & memr_n & memw_n));
      step(1);
    end
    if (done !== 1'h1)
    begin
      error_cnt++;
      summarize();
    end
    chk(seen, ev);
    chk(dk, dma ? 8'h1 << a[2:0] : 8'h0);
    if (k == CYC_IDE) chk(la_o, {~(4'h1 << a[4:3]), a[2:0]});
    else if (k != CYC_REFRESH) chk({la_o, sa}, {a[23:17], a[19:0]});
    mn = w ? CMD16_CYC : CMD8_CYC;
    if (wt > mn) mn = wt;
    if (k < CYC_REFRESH) chk(done16, w);
    if (k < CYC_REFRESH) chk(len >= mn && (!w || len < CMD8_CYC), 1);
  endtask : cyc
  // ************
  // Scenarios
  // ************
  task automatic t_reset(input logic s);
    int n;
    strap = s;
    srst = 1'h1;
    step(6);
    srst = 1'h0;
    for (n = 0; n < 200 && rstdrv; n++) step(1);
    if (rstdrv !== 1'h0)
    begin
      error_cnt++;
      summarize();
    end
    chk(n >= RSTDRV_CYC - 8 && n <= RSTDRV_CYC, 1);
    chk(reloc, s);
    chk(dack_strap, 8'h5A);
    chk({dack_oe_n, spkr_oe_n}, 0);
    $display("reset with strap %0d done", s);
  endtask : t_reset
  task automatic t_cycles;
    cyc(CYC_IOR, 24'h0003F0, 1'h0, 1'h0, 8'h0);
    cyc(CYC_IOR, 24'h000170, 1'h1, 1'h1, 8'h0);
    cyc(CYC_IOW, 24'h000378, 1'h0, 1'h0, 8'h1E);
    cyc(CYC_MEMR, 24'h0C8000, 1'h0, 1'h0, 8'h0);
    cyc(CYC_MEMR, 24'hE40001, 1'h1, 1'h1, 8'h0);
    cyc(CYC_MEMW, 24'h0A0000, 1'h1, 1'h1, 8'h0C);
    cyc(CYC_MEMW, 24'h100000, 1'h0, 1'h0, 8'h0);
    cyc(CYC_REFRESH, 24'h000000, 1'h1, 1'h0, 8'h0);
    cyc(CYC_DMAR, 24'h012345, 1'h1, 1'h0, 8'h0);
    cyc(CYC_DMAW, 24'h0FFFF9, 1'h0, 1'h0, 8'h0);
    for (int i = 0; i < 4; i++) cyc(CYC_IDE, 24'(i * 9), 1'h0, 1'h0, 8'h0);
    $display("bus cycles done");
  endtask : t_cycles
  task automatic t_master;
    master_n = 1'h0;
    ext_refr = 1'h0;
    ext_la = 7'h55;
    step(5);
    chk(req_ready, 0);
    chk(master_ref, 1);
    chk({la_oe_n, master_la}, 8'hD5);
    master_n = 1'h1;
    ext_refr = 1'h1;
    step(5);
    chk(master_ref, 0);
    $display("master cycle done");
  endtask : t_master
  task automatic t_async;
    irq = 16'h4A2F;
    drq = 8'hF3;
    timer2 = 1'h1;
    step(4);
    chk(irq_sync, 16'h4A28);
    chk(drq_pend, 8'hE3);
    chk(spkr_o, 1);
    timer2 = 1'h0;
    step(4);
    chk(spkr_o, 0);
    $display("async inputs done");
  endtask : t_async
  task automatic t_chck;
    int n, c;
    c = 0;
    iochck_n = 1'h0;
    for (n = 0; n < 8; n++)
    begin
      c += int'(chck_ev);
      step(1);
    end
    chk(nmi, 1);
    iochck_n = 1'h1;
    step(5);
    chk(c, 1);
    chk(nmi, 0);
    $display("channel check done");
  endtask : t_chck
  task automatic t_bclk;
    int   c;
    logic b;
    c = 0;
    b = bclk;
    repeat (96)
    begin
      @(negedge link_clk);
      c += int'(bclk != b);
      b = bclk;
    end
    chk(c >= 47 && c <= 49, 1);
    $display("bus clock done");
  endtask : t_bclk
  initial
  begin
    t_reset(1'h1);
    t_cycles();
    t_master();
    t_async();
    t_chck();
    t_bclk();
    t_reset(1'h0);
    summarize();
  end
endmodule : isa_cycle_ctl_tb

// >>> sim/isa_slave_model.sv
// Behavioural ISA slave answering chip-select and ready
`timescale 1ns/1ps
module isa_slave_model (
  // Clock
  input wire logic       clk,
  // Bus side
  input wire logic       cmd_n,
  input wire logic       wide,
  input wire logic [7:0] waits,
  // Answers
  output logic           iocs16_n,
  output logic           memcs16_n,
  output logic           iochrdy
);
  // ************
  // Slave
  // ************
  logic [7:0] cnt_reg = 8'h00;
  logic       cmd_reg = 1'h1;
  // Address decode settles long before the command, so a level is enough
  assign iocs16_n  = ~wide;
  assign memcs16_n = ~wide;
  // Open collector: released means the pull-up wins
  assign iochrdy = (cnt_reg == 8'h00);
  always_ff @(posedge clk)
  begin
    cmd_reg <= cmd_n;
    cnt_reg <= (cmd_reg && !cmd_n) ? waits : cnt_reg - 8'(cnt_reg != 8'h00);
  end
endmodule : isa_slave_model

// >>> src/isa_ctl_pkg.sv
// Package holding constants for the ISA bus cycle control block
package isa_ctl_pkg;

  // ************
  // Cycle kinds
  // ************
  typedef enum logic [2:0] {CYC_IOR, CYC_IOW, CYC_MEMR, CYC_MEMW, CYC_REFRESH, CYC_DMAR,
                            CYC_DMAW, CYC_IDE} cyc_kind_t;

  typedef enum {ST_IDLE, ST_BALE, ST_CMD, ST_WAIT, ST_END} cyc_state_t;

  // ************
  // Timing and layout
  // ************
  localparam int unsigned REF_CLK_MHZ    = 40;
  localparam int unsigned BALE_NS        = 50;
  localparam int unsigned CMD8_NS        = 500;
  localparam int unsigned CMD16_NS       = 125;
  localparam int unsigned RSTDRV_NS      = 1000;
  localparam int unsigned BALE_CYC  = (BALE_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD8_CYC  = (CMD8_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned CMD16_CYC = (CMD16_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned RSTDRV_CYC = (RSTDRV_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 8;
  localparam logic [23:0] LOW_MEG_LIMIT  = 24'h100000;
  localparam int unsigned DRQ_W          = 8;
  localparam logic [7:0]  DRQ_VALID      = 8'hEF;
  localparam int unsigned IRQ_W          = 16;
  localparam logic [15:0] IRQ_VALID      = 16'hCEF8;
  localparam int unsigned BCLK_DIV       = 2;

endpackage : isa_ctl_pkg

// >>> src/isa_cycle_ctl.sv
// ISA bus cycle control: strobes, address, wait states, DMA and strap handling
`timescale 1ns/1ps
module isa_cycle_ctl
  import isa_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               SRST,
  input  wire logic               LINK_CLK,
  // Cycle request from the bridge core
  input  wire logic               REQ_VALID,
  output logic                    REQ_READY,
  input  wire cyc_kind_t          REQ_KIND,
  input  wire logic [23:0]        REQ_ADDR,
  input  wire logic               REQ_HIGH_BYTE,
  input  wire logic               REQ_TC,
  input  wire logic [2:0]         REQ_DMA_CH,
  input  wire logic [1:0]         REQ_IDE_SEL,
  output logic                    DONE,
  output logic                    DONE_16BIT,
  // Address and byte enable
  output logic [19:0]             SA_O,
  output logic [6:0]              LA_O,
  output logic                    LA_OE_N,
  input  wire logic [6:0]         LA_I,
  output logic [6:0]              MASTER_LA,
  output logic                    SBHE_N_O,
  output logic                    SBHE_OE_N,
  output logic                    BALE,
  // Command strobes
  output logic                    IOR_N,
  output logic                    IOW_N,
  output logic                    MEMR_N,
  output logic                    MEMW_N,
  output logic                    SMEMR_N,
  output logic                    SMEMW_N,
  output logic                    CMD_OE_N,
  // Slave answers
  input  wire logic               IOCS16_N,
  input  wire logic               MEMCS16_N,
  input  wire logic               IOCHRDY,
  input  wire logic               IOCHCK_N,
  input  wire logic               MASTER_N,
  // Refresh
  input  wire logic               REFRESH_N_I,
  output logic                    REFRESH_N_O,
  output logic                    REFRESH_N_OE_N,
  output logic                    MASTER_REFRESH,
  // DMA
  output logic                    AEN,
  output logic                    TC,
  input  wire logic [DRQ_W-1:0]   DRQ,
  output logic [DRQ_W-1:0]        DRQ_PENDING,
  input  wire logic [DRQ_W-1:0]   DACK_N_I,
  output logic [DRQ_W-1:0]        DACK_N_O,
  output logic                    DACK_OE_N,
  output logic [DRQ_W-1:0]        DACK_STRAP,
  // Speaker and strap
  input  wire logic               TIMER2_OUT,
  input  wire logic               SPKR_I,
  output logic                    SPKR_O,
  output logic                    SPKR_OE_N,
  output logic                    IDE_BASE_RELOC,
  // Interrupts and errors
  input  wire logic [IRQ_W-1:0]   IRQ,
  output logic [IRQ_W-1:0]        IRQ_SYNC,
  output logic                    CHCK_EVENT,
  output logic                    NMI,
  // Bus reset and clock
  output logic                    RSTDRV,
  output logic                    BCLK
);

  // ************
  // Pin synchronisers
  // ************
  logic [6:0]       pin_s1_reg, pin_s2_reg;
  logic [DRQ_W-1:0] drq_s1_reg, drq_s2_reg, dack_s1_reg, dack_s2_reg;
  logic [IRQ_W-1:0] irq_s1_reg, irq_s2_reg;
  logic [6:0]       la_s1_reg, la_s2_reg;
  wire  logic [6:0] pin_raw = {IOCS16_N, MEMCS16_N, IOCHRDY, IOCHCK_N, MASTER_N,
                               REFRESH_N_I, SPKR_I};

  always_ff @(posedge REF_CLK)
  begin
    pin_s1_reg  <= pin_raw;
    pin_s2_reg  <= pin_s1_reg;
    drq_s1_reg  <= DRQ & DRQ_VALID;
    drq_s2_reg  <= drq_s1_reg;
    dack_s1_reg <= DACK_N_I;
    dack_s2_reg <= dack_s1_reg;
    irq_s1_reg  <= IRQ & IRQ_VALID;
    irq_s2_reg  <= irq_s1_reg;
    la_s1_reg   <= LA_I;
    la_s2_reg   <= la_s1_reg;
  end

  // IOCHRDY is seen two cycles late, so the strobe ends three cycles after a slave releases IOCHRDY
  wire logic iocs16_n_s  = pin_s2_reg[6];
  wire logic memcs16_n_s = pin_s2_reg[5];
  wire logic iochrdy_s   = pin_s2_reg[4];
  wire logic iochck_n_s  = pin_s2_reg[3];
  wire logic master_n_s  = pin_s2_reg[2];
  wire logic refresh_n_s = pin_s2_reg[1];
  wire logic spkr_s      = pin_s2_reg[0];

  assign IRQ_SYNC    = irq_s2_reg;
  assign DRQ_PENDING = drq_s2_reg;
  assign MASTER_LA   = la_s2_reg;

  // ************
  // Reset drive and straps
  // ************
  logic [CNT_W-1:0] rst_cnt_reg;
  logic             strap_done_reg, reloc_reg;
  logic [DRQ_W-1:0] dack_strap_reg;
  wire  logic       powerup   = (rst_cnt_reg != CNT_W'(RSTDRV_CYC));
  wire  logic       strap_now = !strap_done_reg && (rst_cnt_reg == CNT_W'(RSTDRV_CYC - 1));

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      rst_cnt_reg    <= '0;
      strap_done_reg <= 1'b0;
      reloc_reg      <= 1'b0;
      dack_strap_reg <= '0;
    end
    else
    begin
      if (powerup)
        rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
      // Straps caught on the last power-up cycle, after pins settle
      if (strap_now)
      begin
        strap_done_reg <= 1'b1;
        reloc_reg      <= spkr_s;
        dack_strap_reg <= ~dack_s2_reg;
      end
    end
  end

  assign RSTDRV         = powerup;
  assign IDE_BASE_RELOC = reloc_reg;
  assign DACK_STRAP     = dack_strap_reg;
  // Speaker pin released during power-up so the strap can be read
  assign SPKR_OE_N      = powerup;

  // ************
  // Channel check and speaker
  // ************
  logic chck_prev_reg, chck_evt_reg, nmi_reg, spkr_reg;

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      // Idle level of the pin, so no false event follows reset
      chck_prev_reg <= 1'b1;
      chck_evt_reg  <= 1'b0;
      nmi_reg       <= 1'b0;
      spkr_reg      <= 1'b0;
    end
    else
    begin
      chck_prev_reg <= iochck_n_s;
      chck_evt_reg  <= chck_prev_reg & ~iochck_n_s;
      nmi_reg       <= ~iochck_n_s;
      spkr_reg      <= TIMER2_OUT;
    end
  end

  assign CHCK_EVENT = chck_evt_reg;
  assign NMI        = nmi_reg;
  assign SPKR_O     = spkr_reg;

  // ************
  // Cycle sequencer
  // ************
  cyc_state_t       state_reg, state_next;
  cyc_kind_t        kind_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [23:0]      addr_reg;
  logic             hi_reg, tc_reg, is16_reg;
  logic [2:0]       ch_reg;
  logic [1:0]       ide_reg;

  wire logic is_io    = (kind_reg == CYC_IOR) || (kind_reg == CYC_IOW);
  wire logic is_dma   = (kind_reg == CYC_DMAR) || (kind_reg == CYC_DMAW);
  wire logic is_ref   = (kind_reg == CYC_REFRESH);
  wire logic is_ide   = (kind_reg == CYC_IDE);
  wire logic low_meg  = (addr_reg < LOW_MEG_LIMIT);
  wire logic cs16     = is_io ? ~iocs16_n_s : ~memcs16_n_s;
  wire logic idle_bus = master_n_s;
  wire logic cnt_zero = (cnt_reg == '0);
  wire logic [CNT_W-1:0] cmd_len = cs16 ? CNT_W'(CMD16_CYC) : CNT_W'(CMD8_CYC);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (REQ_VALID && idle_bus) state_next = ST_BALE;
      ST_BALE: if (cnt_zero) state_next = ST_CMD;
      ST_CMD:  if (cnt_zero) state_next = ST_WAIT;
      ST_WAIT: if (iochrdy_s) state_next = ST_END;
      ST_END:  state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST || powerup)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST || powerup)
    begin
      kind_reg  <= CYC_IOR;
      cnt_reg   <= '0;
      addr_reg  <= '0;
      hi_reg    <= 1'b0;
      tc_reg    <= 1'b0;
      is16_reg  <= 1'b0;
      ch_reg    <= '0;
      ide_reg   <= '0;
    end
    else
    begin
      if (state_reg == ST_IDLE && state_next == ST_BALE)
      begin
        kind_reg <= REQ_KIND;
        addr_reg <= REQ_ADDR;
        hi_reg   <= REQ_HIGH_BYTE;
        tc_reg   <= REQ_TC;
        ch_reg   <= REQ_DMA_CH;
        ide_reg  <= REQ_IDE_SEL;
        cnt_reg  <= CNT_W'(BALE_CYC - 1);
      end
      else if (state_reg == ST_BALE && cnt_zero)
      begin
        // Width is fixed at the end of BALE, once CS16 has had time to settle
        is16_reg <= cs16;
        cnt_reg  <= cmd_len - CNT_W'(1);
      end
      else if (!cnt_zero)
        cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  assign REQ_READY  = (state_reg == ST_IDLE) && idle_bus && !powerup;
  assign DONE       = (state_reg == ST_END);
  assign DONE_16BIT = is16_reg;

  // ************
  // Pin drive
  // ************
  wire logic active  = (state_reg != ST_IDLE);
  wire logic strobe  = (state_reg == ST_CMD) || (state_reg == ST_WAIT);
  wire logic own_bus = active && idle_bus;

  // ************
  // IDE pin reuse
  // ************
  // Selects on LA20 to LA23, disk address on LA17 to LA19; one select low at a time
  wire logic       ide_cs_1a_n = (ide_reg != 2'h0);
  wire logic       ide_cs_3a_n = (ide_reg != 2'h1);
  wire logic       ide_cs_1b_n = (ide_reg != 2'h2);
  wire logic       ide_cs_3b_n = (ide_reg != 2'h3);
  wire logic [2:0] disk_addr   = addr_reg[2:0];
  wire logic [6:0] la_ide      = {ide_cs_3b_n, ide_cs_1b_n, ide_cs_3a_n, ide_cs_1a_n, disk_addr};

  assign BALE      = (state_reg == ST_BALE) && !is_ide;
  assign SA_O      = addr_reg[19:0];
  assign LA_O      = is_ide ? la_ide : addr_reg[23:17];
  assign LA_OE_N   = !own_bus;
  assign SBHE_N_O  = is_ref ? 1'b1 : !hi_reg;
  assign SBHE_OE_N = !own_bus;

  // One strobe at a time by kind decode, except DMA kinds, which pair an I/O strobe with a memory strobe
  wire logic io_rd = strobe && (kind_reg == CYC_IOR || kind_reg == CYC_DMAW);
  wire logic io_wr = strobe && (kind_reg == CYC_IOW || kind_reg == CYC_DMAR);
  assign IOR_N   = !io_rd;
  assign IOW_N   = !io_wr;
  wire logic mrd = strobe && (kind_reg == CYC_MEMR || kind_reg == CYC_REFRESH
                   || kind_reg == CYC_DMAR);
  wire logic mwr = strobe && (kind_reg == CYC_MEMW || kind_reg == CYC_DMAW);
  assign MEMR_N   = !mrd;
  assign MEMW_N   = !mwr;
  assign SMEMR_N  = !(mrd && (low_meg || is_ref));
  assign SMEMW_N  = !(mwr && low_meg);
  assign CMD_OE_N = !own_bus || is_ide;

  assign REFRESH_N_O    = !(active && is_ref);
  assign REFRESH_N_OE_N = !(own_bus && is_ref);
  assign MASTER_REFRESH = !master_n_s && !refresh_n_s;

  assign AEN = active && is_dma;
  assign TC  = strobe && is_dma && tc_reg;

  // ************
  // DMA acknowledges
  // ************
  genvar g;
  generate
    for (g = 0; g < DRQ_W; g++)
    begin : g_dack
      // Granted channel is acknowledged for the whole DMA cycle
      assign DACK_N_O[g] = !(active && is_dma && ch_reg == 3'(g));
    end
  endgenerate
  assign DACK_OE_N = powerup;

  // ************
  // Bus clock on the link domain
  // ************
  // Free-running divider; the ISA side only needs a clock, not a phase relation
  logic [1:0] bclk_cnt_reg;
  logic       bclk_reg;
  logic       lrst_s1_reg, lrst_s2_reg;

  always_ff @(posedge LINK_CLK)
  begin
    lrst_s1_reg <= SRST;
    lrst_s2_reg <= lrst_s1_reg;
    if (lrst_s2_reg)
    begin
      bclk_cnt_reg <= '0;
      bclk_reg     <= 1'b0;
    end
    else if (bclk_cnt_reg == 2'(BCLK_DIV - 1))
    begin
      bclk_cnt_reg <= '0;
      bclk_reg     <= !bclk_reg;
    end
    else
      bclk_cnt_reg <= bclk_cnt_reg + 2'h1;
  end

  assign BCLK = bclk_reg;

endmodule : isa_cycle_ctl
